//--- cid_pkg.sv
// Purpose: Shared constants and types for the instruction decode subset.
// Assumes: Register file of 256 bytes, flags at 252, stack pointer low byte at 255.
// Notes:   Opcodes not decoded here behave as one-byte no-operations.
package cid_pkg;
    localparam logic [15:0] RESET_PC     = 16'h000C;
    localparam logic [7:0]  REG_IMR      = 8'hFB;
    localparam logic [7:0]  REG_FLAGS    = 8'hFC;
    localparam logic [7:0]  REG_RP       = 8'hFD;
    localparam logic [7:0]  REG_SPL      = 8'hFF;
    localparam int          IMR_ENABLE   = 7;
    localparam logic [3:0]  WORKING_PAGE = 4'hE;
    localparam logic [7:0]  OP_INCREMENT_WORD_DIR  = 8'hA0;
    localparam logic [7:0]  OP_INCREMENT_WORD_IND  = 8'hA1;
    localparam logic [7:0]  OP_INTERRUPT_RETURN      = 8'hBF;
    localparam logic [7:0]  OP_JP_IND    = 8'h30;
    localparam logic [7:0]  OP_NOP       = 8'hFF;
    localparam logic [3:0]  LO_JP        = 4'hD;
    localparam logic [3:0]  LO_JR        = 4'hB;
    localparam logic [3:0]  LO_LD_RW     = 4'h8;
    localparam logic [3:0]  LO_LD_WR     = 4'h9;
    localparam logic [3:0]  LO_LD_IMW    = 4'hC;

    typedef enum logic [2:0] {
        ST_OP   = 3'h0,
        ST_B1   = 3'h1,
        ST_B2   = 3'h2,
        ST_EXEC = 3'h3,
        ST_MEM  = 3'h4
    } cid_state_t;

    // Same bit order as the flag register
    typedef struct packed {
        logic       c;
        logic       z;
        logic       s;
        logic       v;
        logic       d;
        logic       h;
        logic [1:0] rsv;
    } cid_flags_t;

    typedef struct packed {
        logic        req;
        logic        we;
        logic        data_memory_select_n;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } cid_mem_req_t;

    function automatic logic [1:0] cid_len(input logic [7:0] op);
        logic [1:0] n;
        n = 2'd1;
        case (op)
            8'hA0, 8'hA1, 8'h30, 8'hE3, 8'hF3, 8'hC2, 8'hD2, 8'hC3, 8'hD3,
            8'h82, 8'h92, 8'h83, 8'h93: n = 2'd2;
            8'hC7, 8'hD7, 8'hE4, 8'hE5, 8'hE6, 8'hE7, 8'hF5: n = 2'd3;
            default:
            begin
                if (op[3:0] == LO_JP)
                    n = 2'd3;
                else if (op[3:0] == LO_JR || op[3:0] == LO_LD_RW ||
                         op[3:0] == LO_LD_WR || op[3:0] == LO_LD_IMW)
                    n = 2'd2;
            end
        endcase
        return n;
    endfunction
endpackage

//--- cid_cond.sv
// Purpose: Evaluates a four-bit jump condition against the flags.
// Assumes: Flags arrive from the register file, already stable.
// Notes:   Upper code bit inverts the base test, so 1000 is always true.
`timescale 1ns/1ps
module cid_cond
    import cid_pkg::*;
(
    input  wire logic [3:0]         condition_code,
    input  wire cid_pkg::cid_flags_t flags,
    output logic                    cond_true
);
    logic base;

    always_comb
    begin
        case (condition_code[2:0])
            3'h0:    base = 1'b0;
            3'h1:    base = flags.s ^ flags.v;
            3'h2:    base = flags.z | (flags.s ^ flags.v);
            3'h3:    base = flags.c | flags.z;
            3'h4:    base = flags.v;
            3'h5:    base = flags.s;
            3'h6:    base = flags.z;
            default: base = flags.c;
        endcase
        cond_true = base ^ condition_code[3];
    end
endmodule

//--- cid_core.sv
// Purpose: Fetch, decode and execute for a subset of the 8-bit instruction set.
// Assumes: One memory port; a transfer completes in any cycle with req and ack high.
// Notes:   Register file, flags, stack pointer and mask live here as one array.
`timescale 1ns/1ps
module cid_core
    import cid_pkg::*;
#(
    parameter int RF_DEPTH = 256
)
(
    input  wire logic                 mclk,
    input  wire logic                 rst,
    output cid_pkg::cid_mem_req_t      mem,
    input  wire logic [7:0]           mem_rdata,
    input  wire logic                 mem_ack,
    output logic [15:0]               pc,
    output cid_pkg::cid_flags_t        flags,
    output logic [7:0]                stack_pointer,
    output logic [7:0]                interrupt_mask_reg,
    output logic                      instr_done
);
    import cid_pkg::*;

    generate
        if (RF_DEPTH != 256)
            $error("RF_DEPTH must be 256");
    endgenerate

    cid_state_t   st_q, st_d;
    logic [15:0]  pc_q, pc_d;
    logic [7:0]   op_q, op_d, b1_q, b1_d, b2_q, b2_d;
    cid_mem_req_t mem_q, mem_d;
    logic [7:0]   rf_q [RF_DEPTH];
    logic [7:0]   rf_d [RF_DEPTH];
    logic         done_d;
    logic         cc_true;
    logic [3:0]   rp_hi;
    logic [7:0]   loc, rreg, prr, prr1;
    logic         is_ld, is_xfer, xfer_data;

    assign rp_hi     = rf_q[REG_RP][7:4];
    assign rreg      = {rp_hi, b1_q[7:4]};
    // Indirect forms use the working register as a pointer
    assign loc       = op_q[0] ? rf_q[rreg] : rreg;
    assign prr       = {rp_hi, b1_q[3:1], 1'b0};
    assign prr1      = {rp_hi, b1_q[3:1], 1'b1};
    assign is_xfer   = (op_q[3:1] == 3'h1) && (op_q[7:4] == 4'h8 || op_q[7:4] == 4'h9 ||
                                               op_q[7:4] == 4'hC || op_q[7:4] == 4'hD);
    assign xfer_data = (op_q[7:5] == 3'h4);
    assign is_ld     = op_q[3:0] == LO_LD_RW || op_q[3:0] == LO_LD_WR ||
                       op_q[3:0] == LO_LD_IMW || op_q == 8'hC7 || op_q == 8'hD7 ||
                       op_q == 8'hE3 || op_q == 8'hF3 || op_q == 8'hF5 ||
                       (op_q[7:4] == 4'hE && op_q[3:2] == 2'b01);

    cid_cond u_cond (
        .condition_code (op_q[7:4]),
        .flags          (cid_flags_t'(rf_q[REG_FLAGS])),
        .cond_true      (cc_true)
    );

    function automatic logic [7:0] reg_of(input logic [7:0] a, input logic [3:0] rp);
        return (a[7:4] == WORKING_PAGE) ? {rp, a[3:0]} : a;
    endfunction

    always_comb
    begin
        logic [7:0]  a, a1, sp;
        logic [15:0] w;
        cid_flags_t  fl;
        a      = 8'h00;
        a1     = 8'h00;
        sp     = rf_q[REG_SPL];
        w      = 16'h0000;
        fl     = cid_flags_t'(rf_q[REG_FLAGS]);
        st_d   = st_q;
        pc_d   = pc_q;
        op_d   = op_q;
        b1_d   = b1_q;
        b2_d   = b2_q;
        mem_d  = mem_q;
        rf_d   = rf_q;
        done_d = 1'b0;
        case (st_q)
            ST_OP, ST_B1, ST_B2:
            begin
                // Instruction bytes always come from program space
                mem_d.req                  = 1'b1;
                mem_d.we                   = 1'b0;
                mem_d.data_memory_select_n = 1'b1;
                if (mem_q.req && mem_ack)
                begin
                    pc_d = pc_q + 16'h0001;
                    if (st_q == ST_OP)
                        op_d = mem_rdata;
                    else if (st_q == ST_B1)
                        b1_d = mem_rdata;
                    else
                        b2_d = mem_rdata;
                    if ((st_q == ST_OP && cid_len(mem_rdata) == 2'd1) ||
                        (st_q == ST_B1 && cid_len(op_q) == 2'd2) || st_q == ST_B2)
                    begin
                        mem_d.req = 1'b0;
                        st_d      = ST_EXEC;
                    end
                    else
                        st_d = (st_q == ST_OP) ? ST_B1 : ST_B2;
                end
                mem_d.addr = pc_d;
            end
            ST_EXEC:
            begin
                st_d   = ST_OP;
                done_d = 1'b1;
                if (op_q == OP_INCREMENT_WORD_DIR || op_q == OP_INCREMENT_WORD_IND)
                begin
                    a  = reg_of(b1_q, rp_hi);
                    a  = (op_q == OP_INCREMENT_WORD_DIR) ? a : rf_q[a];
                    a1 = a + 8'h01;
                    w  = {rf_q[a], rf_q[a1]} + 16'h0001;
                    rf_d[a]  = w[15:8];
                    rf_d[a1] = w[7:0];
                    fl.z = (w == 16'h0000);
                    fl.s = w[15];
                    fl.v = (w == 16'h8000);
                    rf_d[REG_FLAGS] = fl;
                end
                else if (op_q == OP_INTERRUPT_RETURN)
                begin
                    a  = sp + 8'h01;
                    a1 = sp + 8'h02;
                    rf_d[REG_FLAGS] = rf_q[sp];
                    pc_d            = {rf_q[a], rf_q[a1]};
                    rf_d[REG_SPL]   = sp + 8'h03;
                    rf_d[REG_IMR][IMR_ENABLE] = 1'b1;
                end
                else if (op_q[3:0] == LO_JP)
                begin
                    if (cc_true)
                        pc_d = {b1_q, b2_q};
                end
                else if (op_q == OP_JP_IND)
                begin
                    a  = reg_of(b1_q, rp_hi);
                    a1 = a + 8'h01;
                    pc_d = {rf_q[a], rf_q[a1]};
                end
                else if (op_q[3:0] == LO_JR)
                begin
                    if (cc_true)
                        pc_d = pc_q + {{8{b1_q[7]}}, b1_q};
                end
                else if (op_q[3:0] == LO_LD_RW)
                    rf_d[{rp_hi, op_q[7:4]}] = rf_q[reg_of(b1_q, rp_hi)];
                else if (op_q[3:0] == LO_LD_WR)
                    rf_d[reg_of(b1_q, rp_hi)] = rf_q[{rp_hi, op_q[7:4]}];
                else if (op_q[3:0] == LO_LD_IMW)
                    rf_d[{rp_hi, op_q[7:4]}] = b1_q;
                else if (is_xfer)
                begin
                    // Memory loads and stores finish in ST_MEM
                    done_d = 1'b0;
                    st_d   = ST_MEM;
                    mem_d.req                  = 1'b1;
                    mem_d.we                   = op_q[4];
                    mem_d.data_memory_select_n = ~xfer_data;
                    mem_d.addr                 = {rf_q[prr], rf_q[prr1]};
                    mem_d.wdata                = rf_q[loc];
                end
                else
                begin
                    a  = rf_q[{rp_hi, b1_q[3:0]}];
                    a1 = b2_q + a;
                    case (op_q)
                        8'hC7: rf_d[rreg] = rf_q[a1];
                        8'hD7: rf_d[a1] = rf_q[rreg];
                        8'hE3: rf_d[rreg] = rf_q[a];
                        8'hF3: rf_d[rf_q[rreg]] = rf_q[{rp_hi, b1_q[3:0]}];
                        8'hE4: rf_d[reg_of(b2_q, rp_hi)] = rf_q[reg_of(b1_q, rp_hi)];
                        8'hE5: rf_d[reg_of(b2_q, rp_hi)] = rf_q[rf_q[reg_of(b1_q, rp_hi)]];
                        8'hE6: rf_d[reg_of(b1_q, rp_hi)] = b2_q;
                        8'hE7: rf_d[rf_q[reg_of(b1_q, rp_hi)]] = b2_q;
                        8'hF5: rf_d[rf_q[reg_of(b2_q, rp_hi)]] = rf_q[reg_of(b1_q, rp_hi)];
                        default: ;
                    endcase
                end
            end
            ST_MEM:
            begin
                if (mem_q.req && mem_ack)
                begin
                    mem_d.req = 1'b0;
                    st_d      = ST_OP;
                    done_d    = 1'b1;
                    if (!mem_q.we)
                        rf_d[loc] = mem_rdata;
                    if (op_q[0])
                    begin
                        // Both pointers step after the move
                        w = {rf_q[prr], rf_q[prr1]} + 16'h0001;
                        rf_d[rreg] = rf_q[rreg] + 8'h01;
                        rf_d[prr]  = w[15:8];
                        rf_d[prr1] = w[7:0];
                    end
                end
            end
            default:
                st_d = ST_OP;
        endcase
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            st_q       <= ST_OP;
            pc_q       <= RESET_PC;
            op_q       <= OP_NOP;
            b1_q       <= 8'h00;
            b2_q       <= 8'h00;
            mem_q      <= '0;
            instr_done <= 1'b0;
            for (int i = 0; i < RF_DEPTH; i++)
                rf_q[i] <= 8'h00;
        end
        else
        begin
            st_q       <= st_d;
            pc_q       <= pc_d;
            op_q       <= op_d;
            b1_q       <= b1_d;
            b2_q       <= b2_d;
            mem_q      <= mem_d;
            instr_done <= done_d;
            rf_q       <= rf_d;
        end
    end

    assign mem                = mem_q;
    assign pc                 = pc_q;
    assign flags              = cid_flags_t'(rf_q[REG_FLAGS]);
    assign stack_pointer      = rf_q[REG_SPL];
    assign interrupt_mask_reg = rf_q[REG_IMR];

    chk_fetch_prog: assert property (@(posedge mclk) disable iff (rst)
        (st_q inside {ST_OP, ST_B1, ST_B2} && mem_q.req) |-> mem_q.data_memory_select_n)
        else $error("instruction fetch marked as data space");
    chk_data_select: assert property (@(posedge mclk) disable iff (rst)
        (st_q == ST_MEM && mem_q.req) |-> (mem_q.data_memory_select_n == !xfer_data))
        else $error("data memory select wrong for load");
    chk_interrupt_return_mask: assert property (@(posedge mclk) disable iff (rst)
        (st_q == ST_EXEC && op_q == OP_INTERRUPT_RETURN) |=> interrupt_mask_reg[IMR_ENABLE]
            && stack_pointer == $past(stack_pointer) + 8'h03)
        else $error("interrupt return did not restore mask or pointer");
    chk_nop_still: assert property (@(posedge mclk) disable iff (rst)
        (st_q == ST_EXEC && op_q == OP_NOP) |=> $stable(pc_q) && $stable(flags)
            && $stable(stack_pointer))
        else $error("no-operation changed state");
    chk_jr_target: assert property (@(posedge mclk) disable iff (rst)
        (st_q == ST_EXEC && op_q[3:0] == LO_JR && cc_true)
            |=> pc_q == $past(pc_q) + {{8{$past(b1_q[7])}}, $past(b1_q)})
        else $error("relative jump target wrong");
    chk_jp_skip: assert property (@(posedge mclk) disable iff (rst)
        (st_q == ST_EXEC && op_q[3:0] == LO_JP && !cc_true) |=> $stable(pc_q))
        else $error("absolute jump taken when false");
    chk_ld_flags: assert property (@(posedge mclk) disable iff (rst)
        (st_q == ST_EXEC && is_ld) |=> $stable(flags))
        else $error("register load touched flags");
    chk_increment_word_carry: assert property (@(posedge mclk) disable iff (rst)
        (st_q == ST_EXEC && (op_q == OP_INCREMENT_WORD_DIR || op_q == OP_INCREMENT_WORD_IND))
            |=> flags.c == $past(flags.c))
        else $error("word increment changed carry");
    chk_cond_fixed: assert property (@(posedge mclk) disable iff (rst)
        (op_q[7:4] == 4'h8 |-> cc_true) and (op_q[7:4] == 4'h0 |-> !cc_true))
        else $error("fixed condition codes wrong");
    chk_mem_done: assert property (@(posedge mclk) disable iff (rst)
        (st_q == ST_MEM && mem_q.req && mem_ack) |=> st_q == ST_OP && !mem_q.req
            && instr_done)
        else $error("memory load did not complete");
endmodule

//--- cid_mem_model.sv
// Purpose: Behavioural program and data memory on the far side of the core's memory port.
// Assumes: The select line decides the space; high is program memory, low is data memory.
// Notes:   Answers at once unless stall is high; stall is driven by the bench.
`timescale 1ns/1ps
module cid_mem_model
    import cid_pkg::*;
(
    input  wire logic                  mclk,
    input  wire cid_pkg::cid_mem_req_t mem,
    input  wire logic                  stall,
    output logic [7:0]                 mem_rdata,
    output logic                       mem_ack
);
    logic [7:0] prog_mem [0:65535];
    logic [7:0] data_mem [0:65535];
    logic [7:0] last_q;
    logic [7:0] word;

    initial last_q = 8'h00;

    // Separate arrays, so a transfer with the wrong select lands where it cannot pass
    always @*
    begin
        mem_ack = mem.req & ~stall;
        word = mem.data_memory_select_n ? prog_mem[mem.addr] : data_mem[mem.addr];
        // Outside an answer the bus shows the inverse of the last byte, never a stale copy
        mem_rdata = (mem_ack && !mem.we) ? word : ~last_q;
    end

    always @(posedge mclk)
    begin
        if (mem.req && mem_ack)
        begin
            if (mem.we && mem.data_memory_select_n)
                prog_mem[mem.addr] <= mem.wdata;
            else if (mem.we)
                data_mem[mem.addr] <= mem.wdata;
            else
                last_q <= word;
        end
    end
endmodule

//--- cpu_instruction_decode_subset_test.sv
// Purpose: Self-checking bench running a small program through the decode core.
// Assumes: Register pointer resets to 0, so working registers are registers 00-0F.
// Notes:   Pass 0 answers every request at once, pass 1 stalls the memory at random.
`timescale 1ns/1ps
`define CID_EQ(g, e) if ((g) !== (e)) begin error_cnt++; \
    $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end \
    num_checks++;
module cpu_instruction_decode_subset_test;
    import cid_pkg::*;
    typedef logic [7:0] cid_bytes_t [$];

    logic         mclk;
    logic         rst;
    logic         stall;
    logic         rand_on;
    logic [31:0]  lfsr_q;
    cid_mem_req_t mem;
    logic [7:0]   mem_rdata;
    logic         mem_ack;
    logic [15:0]  pc;
    cid_flags_t   flags;
    logic [7:0]   stack_pointer;
    logic [7:0]   interrupt_mask_reg;
    logic         instr_done;
    int           error_cnt;
    int           num_checks;

    cid_core dut (.mclk(mclk), .rst(rst), .mem(mem), .mem_rdata(mem_rdata),
        .mem_ack(mem_ack), .pc(pc), .flags(flags), .stack_pointer(stack_pointer),
        .interrupt_mask_reg(interrupt_mask_reg), .instr_done(instr_done));
    cid_mem_model u_mem (.mclk(mclk), .mem(mem), .stall(stall), .mem_rdata(mem_rdata),
        .mem_ack(mem_ack));

    initial mclk = 1'b0;
    always #5 mclk = ~mclk;

    function automatic logic [31:0] cid_lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Target of a relative jump: address after the instruction plus the signed byte
    function automatic logic [15:0] cid_rel(input logic [15:0] nxt, input logic [7:0] d);
        return nxt + {{8{d[7]}}, d};
    endfunction

    initial stall = 1'b0;
    always @(negedge mclk)
    begin
        lfsr_q = cid_lfsr(lfsr_q);
        stall = rand_on & lfsr_q[0] & lfsr_q[3];
    end

    task automatic put(input logic [15:0] a, input cid_bytes_t q);
        foreach (q[i])
            u_mem.prog_mem[a + 16'(i)] = q[i];
    endtask

    task automatic load_prog();
        for (int i = 0; i < 65536; i++)
        begin
            u_mem.prog_mem[i] = 8'hFF;
            u_mem.data_mem[i] = 8'h00;
        end
        u_mem.prog_mem[16'h4000] = 8'hAB;
        u_mem.prog_mem[16'h4002] = 8'hCD;
        u_mem.data_mem[16'h4001] = 8'h5A;
        put(16'h000C, '{8'h0C, 8'h12, 8'h1C, 8'h34, 8'h2C, 8'h56,
                        8'h92, 8'h20, 8'hD2, 8'h20, 8'h82, 8'h70,
                        8'h8C, 8'h21, 8'h9C, 8'h00, 8'h92, 8'h78,
                        8'h3C, 8'h9A, 8'h6C, 8'h02, 8'h4C, 8'h20, 8'h5C, 8'h00,
                        8'h93, 8'h64, 8'h93, 8'h64,
                        8'hAC, 8'h30, 8'hBC, 8'h00, 8'hCC, 8'h02,
                        8'hD3, 8'hCA, 8'hD3, 8'hCA,
                        8'hEC, 8'h40, 8'hFC, 8'h00, 8'hDC, 8'h07,
                        8'hC3, 8'hDE, 8'h83, 8'hDE, 8'hC2, 8'h9E,
                        8'h92, 8'h74, 8'h92, 8'h8A, 8'h92, 8'h9E,
                        8'h0C, 8'h7F, 8'h1C, 8'hFF, 8'hA0, 8'hE0,
                        8'h92, 8'h00, 8'h9D, 8'h50, 8'h00});
        put(16'h5000, '{8'h8B, 8'h10});
        // Never-true jump, false less-than, then a no-op and a full backward step
        put(cid_rel(16'h5002, 8'h10), '{8'h0D, 8'h00, 8'h00, 8'h1B, 8'h05, 8'hFF,
                                        8'h8B, 8'h80});
        // Stack bytes are registers 0-2 since the stack pointer starts at 0
        put(cid_rel(16'h501A, 8'h80), '{8'h0C, 8'h40, 8'h1C, 8'h60, 8'h2C, 8'h00,
                                        8'h4C, 8'h20, 8'h5C, 8'h04, 8'h30, 8'hE4});
        put(16'h2004, '{8'hBF});
        // Full-register, working-register, indexed and indirect load forms, an indirect word increment, then conditions
        put(16'h6001, '{8'hE6, 8'h30, 8'h11, 8'hE6, 8'h32, 8'h40, 8'hE7, 8'h32, 8'h22,
                        8'hE5, 8'h32, 8'h33, 8'hE4, 8'h30, 8'h31, 8'hE6, 8'h34, 8'h41,
                        8'hF5, 8'h30, 8'h34, 8'h68, 8'h33, 8'h69, 8'h36,
                        8'hC7, 8'h75, 8'h3C, 8'hD7, 8'h75, 8'h40,
                        8'hE6, 8'h3A, 8'h50, 8'hE6, 8'h50, 8'h12, 8'hE6, 8'h51, 8'hFF,
                        8'hA1, 8'h3A, 8'h6B, 8'h02, 8'hFD, 8'h70, 8'h00});
    endtask

    task automatic wait_pc(input logic [15:0] t);
        int n;
        n = 0;
        while (!(instr_done === 1'b1 && pc === t) && n < 4000)
        begin
            @(negedge mclk);
            n++;
        end
        if (n >= 4000)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, pc, t);
        end
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        #200000;
        error_cnt++;
        close_out();
    end

    initial
    begin
        rst = 1'b1;
        rand_on = 1'b0;
        lfsr_q = 32'h0332;
        error_cnt = 0;
        num_checks = 0;
        for (int p = 0; p < 2; p++)
        begin
            @(negedge mclk);
            rst = 1'b1;
            load_prog();
            rand_on = (p == 1);
            repeat (3) @(negedge mclk);
            rst = 1'b0;
            wait_pc(16'h5000);
            `CID_EQ(flags, 8'h30)
            wait_pc(16'h6001);
            `CID_EQ(flags, 8'h40)
            `CID_EQ(stack_pointer, 8'h03)
            `CID_EQ(interrupt_mask_reg, 8'h80)
            `CID_EQ(u_mem.data_mem[16'h1234], 8'h56)
            `CID_EQ(u_mem.prog_mem[16'h1234], 8'h56)
            `CID_EQ(u_mem.data_mem[16'h2100], 8'h56)
            `CID_EQ(u_mem.data_mem[16'h2000], 8'h56)
            `CID_EQ(u_mem.data_mem[16'h2001], 8'h9A)
            `CID_EQ(u_mem.prog_mem[16'h3000], 8'h56)
            `CID_EQ(u_mem.prog_mem[16'h3001], 8'h9A)
            `CID_EQ(u_mem.data_mem[16'h2002], 8'hAB)
            `CID_EQ(u_mem.data_mem[16'h3002], 8'h5A)
            `CID_EQ(u_mem.data_mem[16'h4002], 8'hCD)
            `CID_EQ(u_mem.data_mem[16'h8000], 8'h80)
            wait_pc(16'h7000);
            `CID_EQ(flags, 8'h00)
            `CID_EQ(dut.rf_q[8'h50], 8'h13)
            `CID_EQ(dut.rf_q[8'h51], 8'h00)
            `CID_EQ(dut.rf_q[8'h31], 8'h11)
            `CID_EQ(dut.rf_q[8'h40], 8'h22)
            `CID_EQ(dut.rf_q[8'h33], 8'h22)
            `CID_EQ(dut.rf_q[8'h41], 8'h11)
            `CID_EQ(dut.rf_q[8'h07], 8'h22)
            `CID_EQ(dut.rf_q[8'h44], 8'h22)
            `CID_EQ(dut.rf_q[8'h06], 8'h22)
            `CID_EQ(dut.rf_q[8'h36], 8'h22)
        end
        close_out();
    end
endmodule
